// *** dsst_pkg.sv ***
/*
 * Constants shared by the digital signal chain self-test: register map,
 * field positions, reset values, serial frame layout, generator setup.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package dsst_pkg;
    // Register offsets on the host serial port
    localparam logic [4:0] OFS_MODE_CONTROL_A    = 5'h01;
    localparam logic [4:0] OFS_MODE_CONTROL_B    = 5'h02;
    localparam logic [4:0] OFS_MODE_CONTROL_C    = 5'h03;
    localparam logic [4:0] OFS_TEST_STATUS       = 5'h04;
    localparam logic [4:0] OFS_SYNC_CONTROL      = 5'h05;
    localparam logic [4:0] OFS_SETTING_BLOCK_6   = 5'h06;
    localparam logic [4:0] OFS_SETTING_BLOCK_12  = 5'h0C;
    localparam logic [4:0] OFS_SETTING_BLOCK_13  = 5'h0D;
    localparam logic [4:0] OFS_SERIAL_OUT_SETUP  = 5'h0E;
    localparam logic [4:0] OFS_SETTING_BLOCK_15  = 5'h0F;

    localparam logic [7:0] REG_RESET_VALUE       = 8'h00;

    // Field positions
    localparam int         SELFTEST_ENABLE_POS   = 3;
    localparam int         SELFTEST_MASK_POS     = 1;
    localparam int         SELFTEST_ERROR_POS    = 0;
    localparam int         SDO_SEL_LSB           = 5;
    localparam logic [2:0] SDO_SEL_ERROR_FLAG    = 3'h5;

    // Serial frame: read flag, two unused bits, 5-bit address, then 8 data bits
    localparam logic [4:0] HSP_INSTR_LAST        = 5'h07;
    localparam logic [4:0] HSP_DATA_FIRST        = 5'h08;
    localparam logic [4:0] HSP_FRAME_LAST        = 5'h0F;
    localparam logic [4:0] HSP_FRAME_BITS        = 5'h10;
    localparam int         HSP_READ_POS          = 6;

    // Test pass
    localparam int         PASS_CYCLES_MAX       = 400000;
    localparam int         PASS_CNT_W            = 19;
    localparam int         DATA_W                = 16;
    localparam int         SUM_W                 = 32;
    localparam logic [15:0] LFSR_SEED            = 16'hACE1;
    localparam logic [31:0] SUM_RESET_VALUE      = 32'h0000_0000;
endpackage : dsst_pkg
`default_nettype wire

// *** dsst_lfsr.sv ***
/*
 * Stimulus generator: 16-bit maximal-length shift register.
 * Assumes the caller restarts it at the start of every pass.
 */
`timescale 1ns/10ps
`default_nettype none
module dsst_lfsr
    import dsst_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              restart,
    input  wire logic              step,
    output logic [DATA_W-1:0]      pattern
);
    typedef struct packed {
        logic [DATA_W-1:0] shift;
    } dsst_lfsr_state_type;

    dsst_lfsr_state_type state_reg;
    dsst_lfsr_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (restart) begin
            state_next.shift = LFSR_SEED;
        end else if (step) begin
            state_next.shift = {state_reg.shift[14:0],
                                state_reg.shift[15] ^ state_reg.shift[13]
                                ^ state_reg.shift[12] ^ state_reg.shift[10]};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.shift <= LFSR_SEED;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pattern = state_reg.shift;
endmodule : dsst_lfsr
`default_nettype wire

// *** dsst_checksum.sv ***
/*
 * Checksum accumulator: rotate-and-xor signature over chain outputs.
 * Assumes clear and accumulate are driven from the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dsst_checksum
    import dsst_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              clear,
    input  wire logic              accumulate,
    input  wire logic [DATA_W-1:0] sample,
    output logic [SUM_W-1:0]       checksum
);
    typedef struct packed {
        logic [SUM_W-1:0] sum;
    } dsst_sum_state_type;

    dsst_sum_state_type state_reg;
    dsst_sum_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (clear) begin
            state_next.sum = SUM_RESET_VALUE;
        end else if (accumulate) begin
            // Rotation keeps sample order significant
            state_next.sum = {state_reg.sum[SUM_W-2:0],
                              state_reg.sum[SUM_W-1]}
                             ^ {{(SUM_W-DATA_W){1'b0}}, sample};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.sum <= SUM_RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign checksum = state_reg.sum;
endmodule : dsst_checksum
`default_nettype wire

// *** dsst_top.sv ***
/*
 * Digital signal chain with built-in self-test and host serial port.
 * Assumes pins (serial port, sync pair, data bus) are asynchronous to
 * core_clk and that core_clk is the full-rate converter clock input.
 */
`timescale 1ns/10ps
`default_nettype none
module dsst_top
    import dsst_pkg::*;
#(
    parameter int          PASS_CYCLES    = PASS_CYCLES_MAX,
    // Arbitrary signature; the real one depends on the chain
    parameter logic [31:0] EXPECTED_SUM   = 32'h0000_0000
)(
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              serial_clock,
    input  wire logic              serial_enable_n,
    input  wire logic              sdio_in,
    output logic                   sdio_out,
    output logic                   sdio_oe,
    output logic                   serial_out_pin,
    input  wire logic              sync_gate_pair,
    input  wire logic [DATA_W-1:0] parallel_data_in,
    output logic [DATA_W-1:0]      chain_data_out,
    output logic                   transmit_gate,
    output logic                   selftest_active
);
    localparam logic [PASS_CNT_W-1:0] PASS_LAST =
        PASS_CNT_W'(PASS_CYCLES - 1);

    typedef struct packed {
        logic [7:0]            mode_a;
        logic [7:0]            mode_b;
        logic [7:0]            mode_c;
        logic [7:0]            sync_ctl;
        logic [7:0]            set6;
        logic [7:0]            set12;
        logic [7:0]            set13;
        logic [7:0]            sdo_setup;
        logic [7:0]            set15;
        logic                  err_flag;
        logic [PASS_CNT_W-1:0] pass_cnt;
        logic [4:0]            bit_cnt;
        logic [7:0]            in_shift;
        logic                  rd_req;
        logic [4:0]            addr;
        logic [7:0]            rd_shift;
        logic                  sdo_bit;
        logic [DATA_W-1:0]     dout;
        logic [DATA_W-1:0]     din_s1;
        logic [DATA_W-1:0]     din_s2;
        logic                  sync_s1;
        logic                  sync_s2;
        logic                  sclk_s1;
        logic                  sclk_s2;
        logic                  sclk_d;
        logic                  sen_s1;
        logic                  sen_s2;
        logic                  sdi_s1;
        logic                  sdi_s2;
    } dsst_state_type;

    dsst_state_type    st_reg;
    dsst_state_type    st_next;
    logic [DATA_W-1:0] pattern;
    logic [SUM_W-1:0]  checksum;
    logic              test_on;
    logic              mask_on;
    logic              pass_end;
    logic              pass_fail;
    logic              sclk_rise;
    logic              sclk_fall;
    logic              wr_commit;
    logic [7:0]        wr_data;
    logic [4:0]        addr_now;
    logic              sdo_shows_flag;

    function automatic logic [7:0] reg_read(input logic [4:0] a,
                                            input dsst_state_type s);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFS_MODE_CONTROL_A:   v = s.mode_a;
            OFS_MODE_CONTROL_B:   v = s.mode_b;
            OFS_MODE_CONTROL_C:   v = s.mode_c;
            OFS_TEST_STATUS:      v = {7'h00, s.err_flag};
            OFS_SYNC_CONTROL:     v = s.sync_ctl;
            OFS_SETTING_BLOCK_6:  v = s.set6;
            OFS_SETTING_BLOCK_12: v = s.set12;
            OFS_SETTING_BLOCK_13: v = s.set13;
            OFS_SERIAL_OUT_SETUP: v = s.sdo_setup;
            OFS_SETTING_BLOCK_15: v = s.set15;
            default:              v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////
    // Self-test engine

    assign test_on   = st_reg.mode_a[SELFTEST_ENABLE_POS];
    assign mask_on   = st_reg.mode_c[SELFTEST_MASK_POS];
    assign pass_end  = test_on && (st_reg.pass_cnt == PASS_LAST);
    assign pass_fail = pass_end && (checksum != EXPECTED_SUM);

    dsst_lfsr u_lfsr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .restart  (!test_on || pass_end),
        .step     (test_on),
        .pattern  (pattern)
    );

    dsst_checksum u_checksum (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .clear      (!test_on || pass_end),
        .accumulate (test_on),
        .sample     (st_next.dout),
        .checksum   (checksum)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial port decode

    assign sclk_rise = st_reg.sclk_s2 && !st_reg.sclk_d;
    assign sclk_fall = !st_reg.sclk_s2 && st_reg.sclk_d;
    assign addr_now  = {st_reg.in_shift[3:0], st_reg.sdi_s2};
    assign wr_data   = {st_reg.in_shift[6:0], st_reg.sdi_s2};
    assign wr_commit = !st_reg.sen_s2 && sclk_rise && !st_reg.rd_req
                       && (st_reg.bit_cnt == HSP_FRAME_LAST);

    always_comb begin
        st_next = st_reg;
        st_next.din_s1  = parallel_data_in;
        st_next.din_s2  = st_reg.din_s1;
        st_next.sync_s1 = sync_gate_pair;
        st_next.sync_s2 = st_reg.sync_s1;
        st_next.sclk_s1 = serial_clock;
        st_next.sclk_s2 = st_reg.sclk_s1;
        st_next.sclk_d  = st_reg.sclk_s2;
        st_next.sen_s1  = serial_enable_n;
        st_next.sen_s2  = st_reg.sen_s1;
        st_next.sdi_s1  = sdio_in;
        st_next.sdi_s2  = st_reg.sdi_s1;

        if (st_reg.sen_s2) begin
            st_next.bit_cnt = 5'h00;
            st_next.rd_req  = 1'b0;
        end else if (sclk_rise && st_reg.bit_cnt != HSP_FRAME_BITS) begin
            st_next.bit_cnt  = st_reg.bit_cnt + 5'h01;
            st_next.in_shift = wr_data;
            if (st_reg.bit_cnt == HSP_INSTR_LAST) begin
                st_next.rd_req   = st_reg.in_shift[HSP_READ_POS];
                st_next.addr     = addr_now;
                st_next.rd_shift = reg_read(addr_now, st_reg);
            end
        end else if (sclk_fall && st_reg.rd_req
                     && st_reg.bit_cnt >= HSP_DATA_FIRST) begin
            // Change on falling edge so host samples on rising edge
            st_next.sdo_bit  = st_reg.rd_shift[7];
            st_next.rd_shift = {st_reg.rd_shift[6:0], 1'b0};
        end

        if (wr_commit) begin
            unique case (st_reg.addr)
                OFS_MODE_CONTROL_A:   st_next.mode_a    = wr_data;
                OFS_MODE_CONTROL_B:   st_next.mode_b    = wr_data;
                OFS_MODE_CONTROL_C:   st_next.mode_c    = wr_data;
                OFS_TEST_STATUS: begin
                    if (!wr_data[SELFTEST_ERROR_POS]) begin
                        st_next.err_flag = 1'b0;
                    end
                end
                OFS_SYNC_CONTROL:     st_next.sync_ctl  = wr_data;
                OFS_SETTING_BLOCK_6:  st_next.set6      = wr_data;
                OFS_SETTING_BLOCK_12: st_next.set12     = wr_data;
                OFS_SETTING_BLOCK_13: st_next.set13     = wr_data;
                OFS_SERIAL_OUT_SETUP: st_next.sdo_setup = wr_data;
                OFS_SETTING_BLOCK_15: st_next.set15     = wr_data;
                default: ;
            endcase
        end

        // Set after clear so an unmasked failing pass is never lost
        if (pass_fail && !mask_on) begin
            st_next.err_flag = 1'b1;
        end

        if (!test_on) begin
            st_next.pass_cnt = '0;
        end else if (pass_end) begin
            st_next.pass_cnt = '0;
        end else begin
            st_next.pass_cnt = st_reg.pass_cnt + PASS_CNT_W'(1);
        end

        // Chain input: generator in test, bus otherwise, zeros w/o sync
        if (!st_reg.sync_s2) begin
            st_next.dout = '0;
        end else if (test_on) begin
            st_next.dout = pattern;
        end else begin
            st_next.dout = st_reg.din_s2;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign sdo_shows_flag = st_reg.sdo_setup[SDO_SEL_LSB +: 3]
                            == SDO_SEL_ERROR_FLAG;
    // Flag on SERIAL_OUT_PIN frees it, so read data moves to the shared data line
    assign serial_out_pin = sdo_shows_flag ? st_reg.err_flag
                                           : st_reg.sdo_bit;
    assign sdio_out        = st_reg.sdo_bit;
    assign sdio_oe         = sdo_shows_flag && st_reg.rd_req
                             && !st_reg.sen_s2
                             && st_reg.bit_cnt >= HSP_DATA_FIRST;
    assign chain_data_out  = st_reg.dout;
    assign transmit_gate   = st_reg.sync_s2;
    assign selftest_active = test_on;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_flag_sticky: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        st_reg.err_flag && !(wr_commit && st_reg.addr == OFS_TEST_STATUS
        && !wr_data[SELFTEST_ERROR_POS]) |=> st_reg.err_flag)
        else $error("error flag dropped without a clearing write");

    chk_flag_clear: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        wr_commit && st_reg.addr == OFS_TEST_STATUS
        && !wr_data[SELFTEST_ERROR_POS] && !pass_fail
        |=> !st_reg.err_flag)
        else $error("writing zero did not clear the error flag");

    chk_fail_sets: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        pass_fail && !mask_on |=> st_reg.err_flag)
        else $error("checksum mismatch did not set the flag");

    chk_mask_gates: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        mask_on && !st_reg.err_flag |=> !st_reg.err_flag)
        else $error("flag rose while masked");

    chk_bus_ignored: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        test_on && st_reg.sync_s2 |=> chain_data_out == $past(pattern))
        else $error("input bus reached chain during self-test");

    chk_sync_zeros: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        !st_reg.sync_s2 |=> chain_data_out == '0)
        else $error("chain not zero while sync low");

    chk_pass_bound: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        st_reg.pass_cnt <= PASS_LAST)
        else $error("pass counter beyond pass length");

    chk_pass_repeat: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        pass_end && $past(test_on) |=> st_reg.pass_cnt == '0
        ##1 (!test_on || st_reg.pass_cnt == PASS_CNT_W'(1)))
        else $error("next pass did not start after pass end");

    chk_sdo_flag: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        sdo_shows_flag |-> serial_out_pin == st_reg.err_flag)
        else $error("serial out not showing error flag");
endmodule : dsst_top
`default_nettype wire

// *** dsst_host_model.sv ***
/*
 * Host controller model: frames on the serial register port.
 * Assumes the bench resolves the sdio wire with a pull-down.
 */
`timescale 1ns/10ps
`default_nettype none
module dsst_host_model
    import dsst_pkg::*;
#(
    parameter int HALF = 6
)(
    input  wire logic core_clk,
    input  wire logic serial_out_pin,
    input  wire logic sdio_line,
    output logic      serial_clock,
    output logic      serial_enable_n,
    output logic      sdio_drive,
    output logic      sdio_drive_en
);
    // Read data taken from the shared data line in 3-wire mode
    logic three_wire;

    initial begin
        three_wire      = 1'b0;
        serial_clock    = 1'b0;
        serial_enable_n = 1'b1;
        sdio_drive      = 1'b0;
        sdio_drive_en   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    ////////////////////////////////////////////////////////////////////
    // Clock idles low outside frames; line released while device answers
    task automatic frame(input logic rd, input logic [4:0] adr,
                         input logic [7:0] wd, output logic [7:0] rdat);
        logic [15:0] word;
        word = {rd, 2'b00, adr, wd};
        rdat = 8'h00;
        serial_enable_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdio_drive_en = !(rd && i < 8);
            sdio_drive    = word[i];
            tick(HALF);
            serial_clock = 1'b1;
            if (rd && i < 8) rdat[i] = three_wire ? sdio_line : serial_out_pin;
            tick(HALF);
            serial_clock = 1'b0;
        end
        sdio_drive_en = 1'b0;
        tick(HALF);
        serial_enable_n = 1'b1;
        tick(HALF);
    endtask : frame

    task automatic write_reg(input logic [4:0] adr, input logic [7:0] d);
        logic [7:0] unused;
        frame(1'b0, adr, d, unused);
    endtask : write_reg

    task automatic read_reg(input logic [4:0] adr, output logic [7:0] d);
        frame(1'b1, adr, 8'h00, d);
    endtask : read_reg
endmodule : dsst_host_model
`default_nettype wire

// *** dsst_top_bench.sv ***
/*
 * Self-checking bench for dsst_top with a host model on the serial port.
 * Assumes dsst_pkg and the host model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module dsst_top_bench;
    import dsst_pkg::*;
    // Short pass keeps the run small
    localparam int PASS = 64;

    logic              core_clk;
    logic              reset_n;
    logic              serial_clock;
    logic              serial_enable_n;
    logic              sdio_drive;
    logic              sdio_drive_en;
    logic              sdio_in;
    logic              sdio_out;
    logic              sdio_oe;
    logic              serial_out_pin;
    logic              sync_gate_pair;
    logic [DATA_W-1:0] parallel_data_in;
    logic [DATA_W-1:0] chain_data_out;
    logic              transmit_gate;
    logic              selftest_active;
    int                failures = 0;
    int                checked = 0;
    logic [4:0]        t_adr [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                                      5'h06, 5'h0C, 5'h0D, 5'h0E, 5'h0F};
    logic [7:0]        t_val [10] = '{8'h18, 8'hEA, 8'hB0, 8'h00, 8'h06,
                                      8'h0F, 8'h0A, 8'h55, 8'h0A, 8'hAA};

    // Pull-down on sdio when neither side drives it
    assign sdio_in = sdio_oe ? sdio_out : (sdio_drive_en ? sdio_drive : 1'b0);

    dsst_top #(.PASS_CYCLES(PASS)) i_dsst_top (
        .core_clk(core_clk), .reset_n(reset_n),
        .serial_clock(serial_clock), .serial_enable_n(serial_enable_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_out_pin(serial_out_pin), .sync_gate_pair(sync_gate_pair),
        .parallel_data_in(parallel_data_in),
        .chain_data_out(chain_data_out), .transmit_gate(transmit_gate),
        .selftest_active(selftest_active)
    );

    dsst_host_model i_dsst_host_model (
        .core_clk(core_clk), .serial_out_pin(serial_out_pin),
        .sdio_line(sdio_in),
        .serial_clock(serial_clock), .serial_enable_n(serial_enable_n),
        .sdio_drive(sdio_drive), .sdio_drive_en(sdio_drive_en)
    );

    // Full-rate converter clock, no multiplied clock
    always #5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_dsst_host_model.write_reg(a, d);
    endtask : wr

    task automatic rd_chk(input string name, input logic [4:0] a,
                          input logic [7:0] e);
        logic [7:0] v;
        i_dsst_host_model.read_reg(a, v);
        check(name, {8'h00, v}, {8'h00, e});
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("active", 16'(selftest_active), 16'h0000);
        for (int i = 0; i < 10; i++) begin
            rd_chk("reset value", t_adr[i], 8'h00);
        end
        wr(5'h1F, 8'hFF);
        rd_chk("unmapped", 5'h1F, 8'h00);
    endtask : t_reset

    task automatic t_sync();
        parallel_data_in = 16'hBEEF;
        tick(4);
        check("chain sync low", chain_data_out, 16'h0000);
        check("gate low", 16'(transmit_gate), 16'h0000);
        sync_gate_pair = 1'b1;
        tick(2);
        check("chain early", chain_data_out, 16'h0000);
        tick(1);
        check("gate high", 16'(transmit_gate), 16'h0001);
        check("chain pass", chain_data_out, 16'hBEEF);
        parallel_data_in = 16'h1234;
        tick(2);
        check("chain hold", chain_data_out, 16'hBEEF);
        tick(1);
        check("chain next", chain_data_out, 16'h1234);
        sync_gate_pair = 1'b0;
        tick(3);
        check("chain off", chain_data_out, 16'h0000);
    endtask : t_sync

    task automatic t_program();
        for (int i = 0; i < 10; i++) begin
            wr(t_adr[i], t_val[i]);
        end
        for (int i = 0; i < 10; i++) begin
            if (i != 3) rd_chk("readback", t_adr[i], t_val[i]);
        end
        check("active on", 16'(selftest_active), 16'h0001);
        check("test sync low", chain_data_out, 16'h0000);
        sync_gate_pair = 1'b1;
    endtask : t_program

    task automatic t_bus();
        logic [15:0] prev;
        int          hits;
        hits = 0;
        parallel_data_in = 16'h5A5A;
        tick(3);
        prev = chain_data_out;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            if (chain_data_out === 16'h5A5A || chain_data_out === prev) hits++;
            prev = chain_data_out;
        end
        check("bus ignored", 16'(hits), 16'h0000);
    endtask : t_bus

    task automatic t_flag();
        tick(PASS);
        rd_chk("flag set", OFS_TEST_STATUS, 8'h01);
        wr(OFS_SERIAL_OUT_SETUP, 8'hAA);
        tick(2);
        check("flag on pin", 16'(serial_out_pin), 16'h0001);
        i_dsst_host_model.three_wire = 1'b1;
        rd_chk("flag on sdio", OFS_TEST_STATUS, 8'h01);
        i_dsst_host_model.three_wire = 1'b0;
        check("sdio released", 16'(sdio_oe), 16'h0000);
        wr(OFS_SERIAL_OUT_SETUP, 8'h0A);
    endtask : t_flag

    task automatic t_sticky();
        wr(OFS_MODE_CONTROL_C, 8'hB2);
        tick(2 * PASS);
        rd_chk("sticky", OFS_TEST_STATUS, 8'h01);
        wr(OFS_TEST_STATUS, 8'h01);
        rd_chk("one no clear", OFS_TEST_STATUS, 8'h01);
        wr(OFS_TEST_STATUS, 8'h00);
        rd_chk("cleared", OFS_TEST_STATUS, 8'h00);
        tick(2 * PASS);
        rd_chk("masked", OFS_TEST_STATUS, 8'h00);
        wr(OFS_MODE_CONTROL_C, 8'hB0);
        rd_chk("repeat pass", OFS_TEST_STATUS, 8'h01);
    endtask : t_sticky

    task automatic t_stop();
        wr(OFS_MODE_CONTROL_A, 8'h10);
        check("active off", 16'(selftest_active), 16'h0000);
        wr(OFS_TEST_STATUS, 8'h00);
        tick(3 * PASS);
        rd_chk("stopped", OFS_TEST_STATUS, 8'h00);
        parallel_data_in = 16'h3C3C;
        tick(3);
        check("bus back", chain_data_out, 16'h3C3C);
    endtask : t_stop

    task automatic t_exit();
        wr(OFS_MODE_CONTROL_A, 8'h18);
        tick(PASS);
        rd_chk("flag again", OFS_TEST_STATUS, 8'h01);
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        check("reset active", 16'(selftest_active), 16'h0000);
        rd_chk("reset enable", OFS_MODE_CONTROL_A, 8'h00);
        rd_chk("reset flag", OFS_TEST_STATUS, 8'h00);
    endtask : t_exit

    ////////////////////////////////////////////////////////////////////
    initial begin
        core_clk         = 1'b0;
        reset_n          = 1'b0;
        sync_gate_pair   = 1'b0;
        parallel_data_in = '0;
        tick(3);
        reset_n = 1'b1;
        t_reset();
        t_sync();
        t_program();
        t_bus();
        t_flag();
        t_sticky();
        t_stop();
        t_exit();
        end_sim();
    end

    // Run needs about 11k cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        failures++;
        end_sim();
    end
endmodule : dsst_top_bench
`default_nettype wire
